/* File: rtl/spi_fram_defines.svh */
// opcodes, status field positions, reset values and protection bounds
`ifndef SPI_FRAM_DEFINES_SVH
`define SPI_FRAM_DEFINES_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OPC_LATCH_SET 8'h06
`define OPC_LATCH_CLEAR 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_ARRAY_READ 8'h03
`define OPC_ARRAY_WRITE 8'h02

// ----------------------------------------------------------------
// status field positions and reset values
// ----------------------------------------------------------------
`define ST_GUARD_PIN_EN_BIT 7
`define ST_GUARD_HI_BIT 3
`define ST_GUARD_LO_BIT 2
`define ST_LATCH_BIT 1
`define NV_FACTORY_VALUE 3'h0

// ----------------------------------------------------------------
// array geometry and protected range starts
// ----------------------------------------------------------------
`define ADDR_W 13
`define PROT_QUARTER_START 13'h1800
`define PROT_HALF_START 13'h1000
`define PROT_ALL_START 13'h0000

`endif

/* File: rtl/spi_fram_pkg.sv */
// types shared by the command decoder and its users
package spi_fram_pkg;

   // ----------------------------------------------------------------
   // status byte layout, msb first
   // ----------------------------------------------------------------
   typedef struct packed {
      logic guard_pin_enable;
      logic [2:0] zero_hi;
      logic block_guard_hi;
      logic block_guard_lo;
      logic write_latch_flag;
      logic zero_lo;
   } status_s;

   // ----------------------------------------------------------------
   // request towards the array
   // ----------------------------------------------------------------
   typedef struct packed {
      logic we;
      logic re;
      logic [12:0] addr;
      logic [7:0] wdata;
   } mem_req_s;

   typedef enum logic [2:0] {
      ST_OPCODE = 3'h0,
      ST_ADDR = 3'h1,
      ST_WDATA = 3'h3,
      ST_RDATA = 3'h2,
      ST_SREAD = 3'h6,
      ST_SWRITE = 3'h7,
      ST_IGNORE = 3'h5,
      ST_DONE = 3'h4
   } cmd_state_e;

endpackage : spi_fram_pkg

/* File: rtl/pin_sync.sv */
// two-flop synchroniser per pin with edge detection on the settled level
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 4
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);

   if (W < 1) begin : g_bad_width
      $error("pin_sync needs at least one pin");
   end

   // ----------------------------------------------------------------
   // per-pin chain: meta flop feeds only the second flop
   // ----------------------------------------------------------------
   for (genvar i = 0; i < W; i++) begin : g_pin
      logic meta_q;
      logic sync_q;
      logic last_q;
      always_ff @(posedge clk_i or posedge reset_i) begin
         if (reset_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
         end else begin
            meta_q <= d_i[i];
            sync_q <= meta_q;
            last_q <= sync_q;
         end
      end
      assign q_o[i] = sync_q;
      assign rise_o[i] = sync_q & ~last_q;
      assign fall_o[i] = ~sync_q & last_q;
   end

endmodule : pin_sync

/* File: rtl/spi_fram_cmd_write_guard.sv */
// opcode decoder, status byte and write guard of a serial memory slave
//
// Notes on behaviour
// R1: 06h sets, 04h clears the write latch
// R2: 05h reads status, 01h writes status
// R3: 03h reads array, 02h writes array
// R4: latch comes up cleared at power-up
// R5: set opcode sets latch, shown at bit 1
// R6: status write data never changes the latch bit
// R7: latch clears at select release after writes
// R8: clear opcode blocks writes, status shows zero
// R9: bits 7,3,2,1: pin enable, guards, latch
// R10: bits 0 and 4-6 read zero always
// R11: block guard bits are kept nonvolatile
// R12: guard field selects none, quarter, half, all
// R13: array write needs latch and unprotected address
// R14: pin enable with pin low refuses status writes
// R15: status write needs latch set
// R16: accepted status write updates enable and guards
// R17: status opcode returns one status byte; code reloads and repeats it for every further byte
// R18: master sets latch first, holds pin high
// R19: factory nonvolatile bits are all zero
// R20: first byte is opcode, msb first
// R21: unknown opcode ignored, output stays off
// R22: sample rising, drive falling, detect mode
// R23: burst hitting protected address stops writing
// R24: status commit after eighth data bit
// R25: status shifted msb first, zeros fixed
`timescale 1ns/1ps
`include "spi_fram_defines.svh"
module spi_fram_cmd_write_guard (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic si_i,
   input wire logic guard_pin_n_i,
   output logic so_o,
   output logic so_oe_o,
   input wire logic [2:0] nv_image_i,
   output logic [2:0] nv_image_o,
   output spi_fram_pkg::mem_req_s mem_req_o,
   input wire logic [7:0] mem_rdata_i,
   output logic mode3_o
);

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   localparam int P_CS = 3;
   localparam int P_SCK = 2;
   localparam int P_SI = 1;
   localparam int P_WP = 0;
   logic [3:0] pin_s;
   logic [3:0] pin_rise;
   logic [3:0] pin_fall;

   pin_sync #(.W(4)) u_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      // select and guard inverted so the flop reset level is the idle pin level
      .d_i({~cs_n_i, sck_i, si_i, ~guard_pin_n_i}),
      .q_o(pin_s),
      .rise_o(pin_rise),
      .fall_o(pin_fall)
   );

   logic sel;
   logic cs_start;
   logic cs_end;
   logic sck_rise;
   logic sck_fall;
   assign sel = pin_s[P_CS];
   assign cs_start = pin_rise[P_CS];
   assign cs_end = pin_fall[P_CS];
   assign sck_rise = sel & pin_rise[P_SCK];
   assign sck_fall = sel & pin_fall[P_SCK];

   // ----------------------------------------------------------------
   // state and shift registers
   // ----------------------------------------------------------------
   spi_fram_pkg::cmd_state_e state_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] sh_q;
   logic [7:0] byte_in;
   logic byte_done;
   logic [`ADDR_W-1:0] addr_q;
   logic addr_byte_q;
   logic is_write_q;
   logic pend_clr_q;
   logic stop_q;
   logic latch_q;
   logic guard_en_q;
   logic [1:0] guard_q;
   logic nv_loaded_q;
   logic mode3_q;
   logic seen_rise_q;
   logic [7:0] out_q;
   logic so_q;
   logic so_oe_q;
   logic rd_load_q;
   spi_fram_pkg::status_s status;
   spi_fram_pkg::mem_req_s req_q;

   assign byte_in = {sh_q, pin_s[P_SI]};
   assign byte_done = sck_rise & (bit_cnt_q == 3'h7); // [R20]

   // ----------------------------------------------------------------
   // protection decode and write permission
   // ----------------------------------------------------------------
   function automatic logic is_protected(input logic [1:0] g, input logic [`ADDR_W-1:0] a);
      logic p;
      p = 1'b0;
      case (g)
         2'h1: p = (a >= `PROT_QUARTER_START);
         2'h2: p = (a >= `PROT_HALF_START);
         2'h3: p = (a >= `PROT_ALL_START);
         default: p = 1'b0;
      endcase
      return p;
   endfunction : is_protected

   logic prot_now;
   logic arr_write_ok;
   logic stat_write_ok;
   assign prot_now = is_protected(guard_q, addr_q); // [R12]
   assign arr_write_ok = latch_q & ~prot_now & ~stop_q; // [R13] [R23]
   // the guard pin only gates status writes, never the array
   assign stat_write_ok = latch_q & ~(guard_en_q & pin_s[P_WP]); // [R14] [R15]

   assign status.guard_pin_enable = guard_en_q; // [R9]
   assign status.zero_hi = 3'h0; // [R10]
   assign status.block_guard_hi = guard_q[1];
   assign status.block_guard_lo = guard_q[0];
   assign status.write_latch_flag = latch_q; // [R5]
   assign status.zero_lo = 1'b0; // [R10]

   // ----------------------------------------------------------------
   // command sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= spi_fram_pkg::ST_OPCODE;
         bit_cnt_q <= 3'h0;
         sh_q <= 7'h00;
         addr_q <= '0;
         addr_byte_q <= 1'b0;
         is_write_q <= 1'b0;
         pend_clr_q <= 1'b0;
         stop_q <= 1'b0;
      end else if (cs_start || cs_end) begin
         // each select cycle carries exactly one opcode
         state_q <= spi_fram_pkg::ST_OPCODE; // [R20]
         bit_cnt_q <= 3'h0;
         addr_byte_q <= 1'b0;
         stop_q <= 1'b0;
         if (cs_start) begin
            pend_clr_q <= 1'b0;
         end
      end else if (sck_rise) begin // [R22]
         bit_cnt_q <= bit_cnt_q + 3'h1;
         sh_q <= byte_in[6:0];
         if (byte_done) begin
            case (state_q)
               spi_fram_pkg::ST_OPCODE: begin
                  if (byte_in == `OPC_LATCH_SET) begin // [R1]
                     state_q <= spi_fram_pkg::ST_DONE;
                  end else if (byte_in == `OPC_LATCH_CLEAR) begin // [R1] [R8]
                     state_q <= spi_fram_pkg::ST_DONE;
                     pend_clr_q <= 1'b1;
                  end else if (byte_in == `OPC_STATUS_READ) begin // [R2]
                     state_q <= spi_fram_pkg::ST_SREAD;
                  end else if (byte_in == `OPC_STATUS_WRITE) begin // [R2]
                     state_q <= spi_fram_pkg::ST_SWRITE;
                     pend_clr_q <= 1'b1;
                  end else if (byte_in == `OPC_ARRAY_READ) begin // [R3]
                     state_q <= spi_fram_pkg::ST_ADDR;
                     is_write_q <= 1'b0;
                  end else if (byte_in == `OPC_ARRAY_WRITE) begin // [R3]
                     state_q <= spi_fram_pkg::ST_ADDR;
                     is_write_q <= 1'b1;
                     pend_clr_q <= 1'b1;
                  end else begin
                     state_q <= spi_fram_pkg::ST_IGNORE; // [R21]
                  end
               end
               spi_fram_pkg::ST_ADDR: begin
                  // upper three address bits are dropped
                  addr_q <= {addr_q[4:0], byte_in};
                  addr_byte_q <= 1'b1;
                  if (addr_byte_q) begin
                     state_q <= is_write_q ? spi_fram_pkg::ST_WDATA : spi_fram_pkg::ST_RDATA;
                  end
               end
               spi_fram_pkg::ST_WDATA: begin
                  if (arr_write_ok) begin
                     addr_q <= addr_q + 13'h1;
                  end else begin
                     stop_q <= 1'b1; // [R23]
                  end
               end
               spi_fram_pkg::ST_RDATA: begin
                  addr_q <= addr_q + 13'h1;
               end
               spi_fram_pkg::ST_SWRITE: begin
                  state_q <= spi_fram_pkg::ST_DONE;
               end
               default: begin
                  state_q <= state_q;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // write latch
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         latch_q <= 1'b0; // [R4]
      end else if (cs_end && pend_clr_q) begin
         latch_q <= 1'b0; // [R7] [R8]
      end else if (byte_done && state_q == spi_fram_pkg::ST_OPCODE &&
                   byte_in == `OPC_LATCH_SET) begin
         latch_q <= 1'b1; // [R5]
      end
   end

   // ----------------------------------------------------------------
   // nonvolatile bits: factory zero, restored once after power-up
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         {guard_en_q, guard_q} <= `NV_FACTORY_VALUE; // [R19]
         nv_loaded_q <= 1'b0;
      end else if (!nv_loaded_q) begin
         // backing store is read after release, never under reset
         {guard_en_q, guard_q} <= nv_image_i; // [R11]
         nv_loaded_q <= 1'b1;
      end else if (byte_done && state_q == spi_fram_pkg::ST_SWRITE && stat_write_ok) begin
         // the latch bit in the data byte is ignored
         guard_en_q <= byte_in[`ST_GUARD_PIN_EN_BIT]; // [R6] [R16] [R24]
         guard_q <= {byte_in[`ST_GUARD_HI_BIT], byte_in[`ST_GUARD_LO_BIT]}; // [R16]
      end
   end
   assign nv_image_o = {guard_en_q, guard_q};

   // ----------------------------------------------------------------
   // array requests
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         req_q <= '0;
         rd_load_q <= 1'b0;
      end else begin
         req_q.we <= 1'b0;
         req_q.re <= 1'b0;
         rd_load_q <= req_q.re;
         if (byte_done && state_q == spi_fram_pkg::ST_WDATA && arr_write_ok) begin
            req_q.we <= 1'b1; // [R13]
            req_q.addr <= addr_q;
            req_q.wdata <= byte_in;
         end else if (byte_done && state_q == spi_fram_pkg::ST_ADDR && addr_byte_q &&
                      !is_write_q) begin
            req_q.re <= 1'b1;
            req_q.addr <= {addr_q[4:0], byte_in};
         end else if (byte_done && state_q == spi_fram_pkg::ST_RDATA) begin
            req_q.re <= 1'b1;
            req_q.addr <= addr_q + 13'h1;
         end
      end
   end
   assign mem_req_o = req_q;

   // ----------------------------------------------------------------
   // mode detect and serial output
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         mode3_q <= 1'b0;
         seen_rise_q <= 1'b0;
      end else if (cs_start) begin
         mode3_q <= pin_s[P_SCK]; // [R22]
         seen_rise_q <= 1'b0;
      end else if (sck_rise) begin
         seen_rise_q <= 1'b1;
      end
   end
   assign mode3_o = mode3_q;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         out_q <= 8'h00;
         so_q <= 1'b0;
         so_oe_q <= 1'b0;
      end else if (cs_start || cs_end) begin
         so_oe_q <= 1'b0;
      end else if (byte_done && (state_q == spi_fram_pkg::ST_SREAD ||
                  (state_q == spi_fram_pkg::ST_OPCODE && byte_in == `OPC_STATUS_READ))) begin
         out_q <= status; // [R17]
      end else if (rd_load_q) begin
         out_q <= mem_rdata_i;
      end else if (sck_fall && (!mode3_q || seen_rise_q) &&
                  (state_q == spi_fram_pkg::ST_SREAD || state_q == spi_fram_pkg::ST_RDATA)) begin
         so_q <= out_q[7]; // [R22] [R25]
         out_q <= {out_q[6:0], 1'b0};
         so_oe_q <= 1'b1; // [R21]
      end
   end
   assign so_o = so_q;
   assign so_oe_o = so_oe_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   logic op_set;
   logic wr_ok_byte;
   assign op_set = byte_done && state_q == spi_fram_pkg::ST_OPCODE && byte_in == `OPC_LATCH_SET;
   assign wr_ok_byte = byte_done && state_q == spi_fram_pkg::ST_SWRITE && stat_write_ok &&
                       nv_loaded_q;

   a_latch_set: assert property (op_set |=> latch_q) // [R5]
      else $error("latch not set by set opcode");
   a_latch_release: assert property (cs_end && pend_clr_q |=> !latch_q ##1 !status[1]) // [R7]
      else $error("latch survived end of write cycle");
   a_latch_source: assert property ($rose(latch_q) |-> $past(op_set)) // [R6]
      else $error("latch set without set opcode");
   a_fixed_zeros: assert property (out_q == status |-> !out_q[0] && out_q[6:4] == 3'h0) // [R10]
      else $error("fixed status bits not zero");
   a_swrite_refuse: assert property (byte_done && state_q == spi_fram_pkg::ST_SWRITE &&
                                     !stat_write_ok && nv_loaded_q |=> $stable(nv_image_o)) // [R14]
      else $error("refused status write changed bits");
   a_swrite_commit: assert property (wr_ok_byte |=>
                                     nv_image_o == {$past(byte_in[7]), $past(byte_in[3:2])}) // [R16]
      else $error("status write not committed");
   a_array_guard: assert property (req_q.we |-> $past(latch_q) &&
                                   !is_protected($past(guard_q), req_q.addr)) // [R13]
      else $error("array write past guard");
   a_burst_stop: assert property (stop_q |-> !req_q.we ##1 !req_q.we) // [R23]
      else $error("write after protected stop");
   a_ignore_quiet: assert property (state_q == spi_fram_pkg::ST_IGNORE |-> !so_oe_q) // [R21]
      else $error("output driven after unknown opcode");

   c_status_read: cover property (state_q == spi_fram_pkg::ST_SREAD && so_oe_q);
   c_status_write: cover property (wr_ok_byte);
   c_array_write: cover property (req_q.we);
   c_unknown_op: cover property (state_q == spi_fram_pkg::ST_IGNORE);

endmodule : spi_fram_cmd_write_guard

/* File: tb/spi_master_model.sv */
// spi master model: frames of bytes in mode 0 or mode 3
`timescale 1ns/1ps
module spi_master_model (
   input wire logic clk_i,
   input wire logic so_i,
   input wire logic so_oe_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic si_o
);
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      si_o = 1'b0;
   end

   // ----------------------------------------------------------------
   // one select cycle: sck half period 4 clk, stands still outside frames
   // ----------------------------------------------------------------
   task automatic frame(input logic [7:0] tx[$], input logic mode,
                        output logic [7:0] rx, output logic oe_seen);
      oe_seen = 1'b0;
      rx = 8'h00;
      sck_o <= mode;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      foreach (tx[i]) begin
         for (int b = 7; b >= 0; b--) begin
            sck_o <= 1'b0;
            si_o <= tx[i][b];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            // sampled mid-high: output settled well after the fall
            repeat (2) @(posedge clk_i);
            rx = {rx[6:0], so_i};
            oe_seen = oe_seen | so_oe_i;
            repeat (2) @(posedge clk_i);
         end
      end
      sck_o <= mode;
      repeat (2) @(posedge clk_i);
      cs_n_o <= 1'b1;
      // released line must not keep showing the last bit
      si_o <= ~si_o;
      repeat (6) @(posedge clk_i);
   endtask : frame
endmodule : spi_master_model

/* File: tb/spi_fram_cmd_write_guard_test.sv */
// self-checking bench for the command decoder and write guard
`timescale 1ns/1ps
module spi_fram_cmd_write_guard_test;
   typedef struct packed {
      logic latch_set;
      logic pin_n;
      logic [7:0] wdata;
      logic [7:0] exp;
   } row_s;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, sck, si, so, so_oe, mode3;
   logic guard_pin_n = 1'b1;
   logic [2:0] nv_in = 3'h0;
   logic [2:0] nv_out;
   logic [7:0] mem_rdata = 8'h00;
   spi_fram_pkg::mem_req_s mem_req;
   logic [7:0] rx_byte;
   logic rx_oe;
   int n_mismatch = 0;
   int tests_run = 0;
   int n_we = 0;
   logic [12:0] we_addr = 13'h0000;
   logic [12:0] re_addr = 13'h0000;
   logic [7:0] we_data = 8'h00;
   row_s rows [5] = '{
      '{1'b0, 1'b1, 8'h8c, 8'h00},
      '{1'b1, 1'b1, 8'h8f, 8'h8c},
      '{1'b1, 1'b0, 8'h00, 8'h8c},
      '{1'b1, 1'b1, 8'h04, 8'h04},
      '{1'b1, 1'b0, 8'h08, 8'h08}
   };

   always #10 clk = ~clk;

   spi_fram_cmd_write_guard i_spi_fram_cmd_write_guard (
      .clk_i(clk), .reset_i(rst), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
      .guard_pin_n_i(guard_pin_n), .so_o(so), .so_oe_o(so_oe), .nv_image_i(nv_in),
      .nv_image_o(nv_out), .mem_req_o(mem_req), .mem_rdata_i(mem_rdata), .mode3_o(mode3)
   );

   spi_master_model i_spi_master_model (
      .clk_i(clk), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n), .sck_o(sck), .si_o(si)
   );

   // ----------------------------------------------------------------
   // array side: data depends on address so a wrong address shows
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (mem_req.re) begin
         mem_rdata <= mem_req.addr[7:0] ^ 8'h5a;
         re_addr <= mem_req.addr;
      end
      if (mem_req.we) begin
         n_we <= n_we + 1;
         we_addr <= mem_req.addr;
         we_data <= mem_req.wdata;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic xfer(input logic [7:0] tx[$], input logic mode = 1'b0);
      i_spi_master_model.frame(tx, mode, rx_byte, rx_oe);
   endtask : xfer

   task automatic read_status(input logic [7:0] exp);
      xfer('{8'h05, 8'h00});
      check("status byte", {8'h00, rx_byte}, {8'h00, exp});
      check("status drive", {15'h0000, rx_oe}, 16'h0001);
   endtask : read_status

   task automatic power_cycle;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : power_cycle

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : complete_run

   initial begin
      repeat (100000) @(posedge clk);
      n_mismatch++;
      $display("ERROR run length expected end seen hang");
      complete_run();
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      check("reset nv", {13'h0000, nv_out}, 16'h0000);
      check("reset drive", {15'h0000, so_oe}, 16'h0000);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      check("factory nv", {13'h0000, nv_out}, 16'h0000);
      foreach (rows[k]) begin
         if (rows[k].latch_set)
            xfer('{8'h06});
         guard_pin_n <= rows[k].pin_n;
         xfer('{8'h01, rows[k].wdata});
         guard_pin_n <= 1'b1;
         read_status(rows[k].exp);
         check("nv image", {13'h0000, nv_out},
               {13'h0000, rows[k].exp[7], rows[k].exp[3:2]});
      end
      // latch set then cleared by opcode
      xfer('{8'h06});
      read_status(8'h0a);
      xfer('{8'h04});
      read_status(8'h08);
      // unknown opcode followed by a valid one in the same cycle
      xfer('{8'hff, 8'h05, 8'h00});
      check("unknown opcode drive", {15'h0000, rx_oe}, 16'h0000);
      read_status(8'h08);
      // burst write that runs into the protected upper half
      xfer('{8'h06});
      xfer('{8'h02, 8'h0f, 8'hff, 8'ha5, 8'h3c});
      check("write pulses", n_we[15:0], 16'h0001);
      check("write addr", {3'h0, we_addr}, 16'h0fff);
      check("write data", {8'h00, we_data}, 16'h00a5);
      // latch already cleared by the burst's select release
      xfer('{8'h02, 8'h00, 8'h10, 8'h77});
      check("write without latch", n_we[15:0], 16'h0001);
      // array read, upper address bits dropped
      xfer('{8'h03, 8'he1, 8'h23, 8'h00});
      // one read request per byte: the next address is already asked for
      check("read addr", {3'h0, re_addr}, 16'h0124);
      check("mode 0 flag", {15'h0000, mode3}, 16'h0000);
      check("read data", {8'h00, rx_byte}, 16'h0079);
      // mode 3 select with sck high
      xfer('{8'h05, 8'h00}, 1'b1);
      check("mode 3 flag", {15'h0000, mode3}, 16'h0001);
      check("mode 3 status", {8'h00, rx_byte}, 16'h0008);
      // power cycle with the latch set: guard bits kept, latch lost
      xfer('{8'h06});
      nv_in <= nv_out;
      power_cycle();
      read_status(8'h08);
      complete_run();
   end
endmodule : spi_fram_cmd_write_guard_test
